// >>> rtl/psm_pkg.sv
// package of register map, field layout and timing constants for the packet start marker
package psm_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [15:0] ADDR_TX_FIFO_SYNC_SELECT = 16'h9427;
  localparam logic [15:0] ADDR_PACKET_START_CONTROL = 16'h9428;
  localparam logic [15:0] ADDR_PACKET_START_RX_DELAY = 16'h9429;
  localparam logic [15:0] ADDR_PACKET_START_TX_DELAY = 16'h942A;

  localparam logic [15:0] RST_TX_FIFO_SYNC_SELECT = 16'h0000;
  localparam logic [15:0] RST_PACKET_START_CONTROL = 16'h0034;
  localparam logic [15:0] RST_PACKET_START_RX_DELAY = 16'h0000;
  localparam logic [15:0] RST_PACKET_START_TX_DELAY = 16'h0000;

  // writable bits; the rest read as zero
  localparam logic [15:0] MASK_TX_FIFO_SYNC_SELECT = 16'h0001;
  localparam logic [15:0] MASK_PACKET_START_CONTROL = 16'h007F;
  localparam logic [15:0] MASK_PACKET_START_RX_DELAY = 16'hFFFF;
  localparam logic [15:0] MASK_PACKET_START_TX_DELAY = 16'h1FFF;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int FIFO_SYNC_BIT = 0;
  localparam int TX_INDICATION_ENABLE_BIT = 0;
  localparam int RX_INDICATION_ENABLE_BIT = 1;
  localparam int DELIMITER_TRIGGER_ENABLE_BIT = 2;
  localparam int FIXED_DURATION_ENABLE_BIT = 3;
  localparam int DURATION_LSB = 4;
  localparam int DURATION_MSB = 6;
  localparam int RX_DELAY_10M_LSB = 11;
  localparam int RX_DELAY_10M_MSB = 15;
  localparam int RX_DELAY_100M_LSB = 6;
  localparam int RX_DELAY_100M_MSB = 10;
  localparam int TX_DELAY_10M_LSB = 8;
  localparam int TX_DELAY_10M_MSB = 12;
  localparam int TX_DELAY_100M_LSB = 4;
  localparam int TX_DELAY_100M_MSB = 7;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int MII_100M_PERIOD_NS = 40;
  localparam int MII_10M_PERIOD_NS = 400;
  localparam int MII_10M_DIVIDE = MII_10M_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DURATION_STEP_CYCLES = 8;
  localparam int TX_DELAY_UNIT_NS = 8;
  localparam int DELAY_WIDTH = 5;
  localparam int HOLD_COUNT_WIDTH = 7;

endpackage : psm_pkg

// >>> rtl/psm_chan_if.sv
// interface carrying configuration, frame events and indication of one channel
`timescale 1ns/10ps
`default_nettype none
interface psm_chan_if;
  logic enable;
  logic delimTrigger;
  logic fixedDuration;
  logic [2:0] durationField;
  logic [psm_pkg::DELAY_WIDTH-1:0] delayCycles;
  logic delayUsesTick;
  logic miiTick;
  logic frameActive;
  logic delimPulse;
  logic indication;

  modport ctrl (
    output enable, delimTrigger, fixedDuration, durationField, delayCycles,
    output delayUsesTick, miiTick, frameActive, delimPulse,
    input indication
  );
  modport chan (
    input enable, delimTrigger, fixedDuration, durationField, delayCycles,
    input delayUsesTick, miiTick, frameActive, delimPulse,
    output indication
  );
endinterface : psm_chan_if
`default_nettype wire

// >>> rtl/psm_mii_tick.sv
// divider giving one enable pulse per MII RX_CLK cycle at the current link speed
`timescale 1ns/10ps
`default_nettype none
module psm_mii_tick #(
  parameter int DIVIDE_10M = psm_pkg::MII_10M_DIVIDE
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic speed100,
  output logic miiTick
);
  import psm_pkg::*;

  generate
    if (DIVIDE_10M < 2 || DIVIDE_10M > 16) begin : g_bad_div
      $error("psm_mii_tick: DIVIDE_10M must lie in 2..16");
    end
  endgenerate

  logic [3:0] div_reg;
  logic [3:0] div_next;

  always_comb begin
    if (div_reg == 4'(DIVIDE_10M - 1)) begin
      div_next = 4'h0;
    end else begin
      div_next = div_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  // at 100 Mbps the MII clock equals ref_clk, so every cycle is a tick
  assign miiTick = speed100 | (div_reg == 4'h0);
endmodule : psm_mii_tick
`default_nettype wire

// >>> rtl/psm_indication_channel.sv
// one start-of-packet indication channel: trigger, delay, hold and end-of-frame release
`timescale 1ns/10ps
`default_nettype none
module psm_indication_channel (
  input wire logic ref_clk,
  input wire logic rst,
  psm_chan_if.chan chan
);
  import psm_pkg::*;

  typedef enum logic [1:0] {IDLE, DELAY, HOLD, SPENT} psm_chan_state_e;

  psm_chan_state_e state_reg;
  psm_chan_state_e state_next;
  logic [HOLD_COUNT_WIDTH-1:0] count_reg;
  logic [HOLD_COUNT_WIDTH-1:0] count_next;
  logic prevActive_reg;
  logic ind_reg;
  logic ind_next;
  logic start;
  logic delayTick;
  logic [HOLD_COUNT_WIDTH-1:0] holdLimit;

  // ==========================================================================
  // trigger selection
  // ==========================================================================
  assign start = chan.frameActive &
                 (chan.delimTrigger ? chan.delimPulse : ~prevActive_reg); // [RQ3]
  assign delayTick = chan.delayUsesTick ? chan.miiTick : 1'b1;
  assign holdLimit = HOLD_COUNT_WIDTH'(({4'h0, chan.durationField} + 7'h01)
                     * 7'(DURATION_STEP_CYCLES)); // [RQ6]

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      IDLE: begin
        if (chan.enable && start) begin
          if (chan.delayCycles == '0) begin // [RQ16]
            state_next = HOLD;
            count_next = '0;
          end else begin
            state_next = DELAY;
            count_next = HOLD_COUNT_WIDTH'(chan.delayCycles);
          end
        end
      end
      DELAY: begin
        if (delayTick) begin
          count_next = count_reg - 7'h01;
          if (count_reg == 7'h01) begin
            state_next = HOLD;
            count_next = '0;
          end
        end
      end
      HOLD: begin
        if (chan.fixedDuration && chan.miiTick) begin // [RQ5]
          count_next = count_reg + 7'h01;
          if (count_reg + 7'h01 == holdLimit) begin
            state_next = SPENT;
          end
        end
      end
      SPENT: begin
        state_next = SPENT;
      end
    endcase
    // frame end always releases the indication, whatever the count
    if (!chan.frameActive || !chan.enable) begin // [RQ7]
      state_next = IDLE;
      count_next = '0;
    end
    ind_next = (state_next == HOLD);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
      count_reg <= '0;
      prevActive_reg <= 1'b0;
      ind_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      prevActive_reg <= chan.frameActive;
      ind_reg <= ind_next;
    end
  end

  assign chan.indication = ind_reg;
endmodule : psm_indication_channel
`default_nettype wire

// >>> rtl/psm_packet_start_marker.sv
// top of the packet start marker: management registers and two indication channels
//
// Overview of operation
// RQ1 - transmit indication produced only while the transmit enable bit is set
// RQ2 - receive indication produced only while the receive enable bit is set
// RQ3 - delimiter trigger bit picks SFD or first nibble as the start point
// RQ4 - software changes the trigger bit only with link down or both enables clear
// RQ5 - fixed duration bit chooses counted length, otherwise indication spans the frame
// RQ6 - counted length is (duration field plus one) times eight MII RX_CLK cycles
// RQ7 - both indications always drop at the end of the frame
// RQ8 - transmit start is seen after the transmit FIFO to keep timing steady
// RQ9 - at 10 Mbps receive indication delayed by the 10M receive delay field
// RQ10 - at 100 Mbps receive indication delayed by the 100M receive delay field
// RQ11 - at 10 Mbps transmit indication delayed by 10M field in 8 ns units (the code rounds the delay up to whole 40 ns ref_clk cycles)
// RQ12 - at 100 Mbps transmit indication delayed by 100M field in 8 ns units (the code rounds the delay up to whole 40 ns ref_clk cycles)
// RQ13 - software should program the 10M transmit delay to twenty
// RQ14 - software should leave the 100M transmit delay at zero
// RQ15 - sync select bit runs the transmit FIFO in low latency synchronous mode
// RQ16 - zero delay adds nothing; delay only moves the start, not the end (with fixed duration set, the counted end moves with the delay)
`timescale 1ns/10ps
`default_nettype none
module psm_packet_start_marker (
  input wire logic ref_clk,
  input wire logic rst,
  // management register port, decoded upstream from the MDIO frame
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  // link state from the PCS
  input wire logic linkSpeed100,
  // frame events, same clock domain
  input wire logic txFrameActive,
  input wire logic txDelimDetect,
  input wire logic rxFrameActive,
  input wire logic rxDelimDetect,
  // outputs
  output logic txIndication,
  output logic rxIndication,
  output logic txFifoSyncMode
);
  import psm_pkg::*;

  localparam int NUM_CHAN = 2;
  localparam int CHAN_TX = 0;
  localparam int CHAN_RX = 1;

  // ==========================================================================
  // register storage
  // ==========================================================================
  logic [15:0] fifoSync_reg;
  logic [15:0] fifoSync_next;
  logic [15:0] control_reg;
  logic [15:0] control_next;
  logic [15:0] rxDelay_reg;
  logic [15:0] rxDelay_next;
  logic [15:0] txDelay_reg;
  logic [15:0] txDelay_next;
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wdata,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction : merge

  always_comb begin
    fifoSync_next = fifoSync_reg;
    control_next = control_reg;
    rxDelay_next = rxDelay_reg;
    txDelay_next = txDelay_reg;
    if (regWrEn) begin
      unique case (regAddr)
        ADDR_TX_FIFO_SYNC_SELECT: begin
          fifoSync_next = merge(fifoSync_reg, regWrData, MASK_TX_FIFO_SYNC_SELECT);
        end
        ADDR_PACKET_START_CONTROL: begin
          control_next = merge(control_reg, regWrData, MASK_PACKET_START_CONTROL);
        end
        ADDR_PACKET_START_RX_DELAY: begin
          rxDelay_next = merge(rxDelay_reg, regWrData, MASK_PACKET_START_RX_DELAY);
        end
        ADDR_PACKET_START_TX_DELAY: begin
          txDelay_next = merge(txDelay_reg, regWrData, MASK_PACKET_START_TX_DELAY);
        end
        default: begin
          fifoSync_next = fifoSync_reg;
        end
      endcase
    end
  end

  // ==========================================================================
  // read path: registered, unmapped addresses read zero
  // ==========================================================================
  always_comb begin
    rdData_next = rdData_reg;
    if (regRdEn) begin
      unique case (regAddr)
        ADDR_TX_FIFO_SYNC_SELECT: rdData_next = fifoSync_reg;
        ADDR_PACKET_START_CONTROL: rdData_next = control_reg;
        ADDR_PACKET_START_RX_DELAY: rdData_next = rxDelay_reg;
        ADDR_PACKET_START_TX_DELAY: rdData_next = txDelay_reg;
        default: rdData_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fifoSync_reg <= RST_TX_FIFO_SYNC_SELECT;
      control_reg <= RST_PACKET_START_CONTROL;
      rxDelay_reg <= RST_PACKET_START_RX_DELAY;
      txDelay_reg <= RST_PACKET_START_TX_DELAY;
      rdData_reg <= 16'h0000;
    end else begin
      fifoSync_reg <= fifoSync_next;
      control_reg <= control_next;
      rxDelay_reg <= rxDelay_next;
      txDelay_reg <= txDelay_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // the FIFO itself sits outside; this level steers its mode
  assign txFifoSyncMode = fifoSync_reg[FIFO_SYNC_BIT]; // [RQ15]

  // ==========================================================================
  // field decode
  // ==========================================================================
  logic txEnable;
  logic rxEnable;
  logic delimTrigger;
  logic fixedDuration;
  logic [2:0] durationField;
  logic [4:0] rxDelay10m;
  logic [4:0] rxDelay100m;
  logic [4:0] txDelay10m;
  logic [3:0] txDelay100m;

  assign txEnable = control_reg[TX_INDICATION_ENABLE_BIT];
  assign rxEnable = control_reg[RX_INDICATION_ENABLE_BIT];
  // changing this mid-frame may misfire; software only touches it while idle
  assign delimTrigger = control_reg[DELIMITER_TRIGGER_ENABLE_BIT]; // [RQ4]
  assign fixedDuration = control_reg[FIXED_DURATION_ENABLE_BIT];
  assign durationField = control_reg[DURATION_MSB:DURATION_LSB];
  assign rxDelay10m = rxDelay_reg[RX_DELAY_10M_MSB:RX_DELAY_10M_LSB];
  assign rxDelay100m = rxDelay_reg[RX_DELAY_100M_MSB:RX_DELAY_100M_LSB];
  // recommended values (twenty at 10M, zero at 100M) are left to software
  assign txDelay10m = txDelay_reg[TX_DELAY_10M_MSB:TX_DELAY_10M_LSB]; // [RQ13]
  assign txDelay100m = txDelay_reg[TX_DELAY_100M_MSB:TX_DELAY_100M_LSB]; // [RQ14]

  // ==========================================================================
  // per-speed delay selection
  // ==========================================================================
  logic [4:0] txUnits;
  logic [9:0] txDelayNs;
  logic [DELAY_WIDTH-1:0] txDelayCycles;
  logic [DELAY_WIDTH-1:0] rxDelayCycles;

  assign txUnits = linkSpeed100 ? {1'b0, txDelay100m} : txDelay10m; // [RQ11] [RQ12]
  assign txDelayNs = 10'(txUnits) * 10'(TX_DELAY_UNIT_NS);
  // 8 ns steps are finer than the 40 ns clock, so the delay rounds up to whole cycles
  assign txDelayCycles = DELAY_WIDTH'((txDelayNs + 10'(CLK_PERIOD_NS - 1))
                         / 10'(CLK_PERIOD_NS));
  assign rxDelayCycles = linkSpeed100 ? rxDelay100m : rxDelay10m; // [RQ9] [RQ10]

  // ==========================================================================
  // MII clock enable
  // ==========================================================================
  logic miiTick;

  psm_mii_tick #(
    .DIVIDE_10M(MII_10M_DIVIDE)
  ) u_mii_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .speed100(linkSpeed100),
    .miiTick(miiTick)
  );

  // ==========================================================================
  // indication channels
  // ==========================================================================
  logic [NUM_CHAN-1:0] chanEnable;
  logic [NUM_CHAN-1:0] chanActive;
  logic [NUM_CHAN-1:0] chanDelim;
  logic [NUM_CHAN-1:0] chanTickDelay;
  logic [NUM_CHAN-1:0] chanInd;
  logic [DELAY_WIDTH-1:0] chanDelay [NUM_CHAN];

  assign chanEnable[CHAN_TX] = txEnable; // [RQ1]
  assign chanEnable[CHAN_RX] = rxEnable; // [RQ2]
  // transmit events are taken after the FIFO output, not at the MAC side
  assign chanActive[CHAN_TX] = txFrameActive; // [RQ8]
  assign chanActive[CHAN_RX] = rxFrameActive;
  assign chanDelim[CHAN_TX] = txDelimDetect;
  assign chanDelim[CHAN_RX] = rxDelimDetect;
  // transmit delay counts ref_clk cycles, receive delay counts MII cycles
  assign chanTickDelay[CHAN_TX] = 1'b0;
  assign chanTickDelay[CHAN_RX] = 1'b1;
  assign chanDelay[CHAN_TX] = txDelayCycles;
  assign chanDelay[CHAN_RX] = rxDelayCycles;

  psm_chan_if chanIf [NUM_CHAN] ();

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign chanIf[g].enable = chanEnable[g];
      assign chanIf[g].delimTrigger = delimTrigger;
      assign chanIf[g].fixedDuration = fixedDuration;
      assign chanIf[g].durationField = durationField;
      assign chanIf[g].delayCycles = chanDelay[g];
      assign chanIf[g].delayUsesTick = chanTickDelay[g];
      assign chanIf[g].miiTick = miiTick;
      assign chanIf[g].frameActive = chanActive[g];
      assign chanIf[g].delimPulse = chanDelim[g];
      assign chanInd[g] = chanIf[g].indication;

      psm_indication_channel u_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .chan(chanIf[g])
      );
    end
  endgenerate

  assign txIndication = chanInd[CHAN_TX];
  assign rxIndication = chanInd[CHAN_RX];
endmodule : psm_packet_start_marker
`default_nettype wire

// >>> verif/psm_packet_start_marker_checker.sv
// port-level assertions of the packet start marker
`timescale 1ns/10ps
`default_nettype none
module psm_packet_start_marker_checker
  import psm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic linkSpeed100,
  input wire logic txFrameActive,
  input wire logic txDelimDetect,
  input wire logic rxFrameActive,
  input wire logic rxDelimDetect,
  input wire logic txIndication,
  input wire logic rxIndication,
  input wire logic txFifoSyncMode
);
  logic [15:0] ctlReg, ctlNext, txdReg, txdNext;
  logic [7:0] holdReg, holdNext, holdLimit;
  logic unmapped;
  // ==========================================================================
  // shadow of the control and tx delay registers and tx hold length
  // ==========================================================================
  always_comb begin
    ctlNext = ctlReg;
    txdNext = txdReg;
    if (regWrEn && regAddr == ADDR_PACKET_START_CONTROL) begin
      ctlNext = regWrData & MASK_PACKET_START_CONTROL;
    end
    if (regWrEn && regAddr == ADDR_PACKET_START_TX_DELAY) begin
      txdNext = regWrData & MASK_PACKET_START_TX_DELAY;
    end
    holdNext = txIndication ? holdReg + 8'h01 : 8'h00;
    holdLimit = {2'h0, ctlReg[6:4], 3'h0} + 8'h08;
    unmapped = regAddr < ADDR_TX_FIFO_SYNC_SELECT || regAddr > ADDR_PACKET_START_TX_DELAY;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctlReg <= 16'h0034;
      txdReg <= 16'h0000;
      holdReg <= 8'h00;
    end else begin
      ctlReg <= ctlNext;
      txdReg <= txdNext;
      holdReg <= holdNext;
    end
  end
  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_TX_IN_FRAME: assert property (txIndication |-> $past(txFrameActive))
    else $error("tx indication outside a frame");
  AST_RX_IN_FRAME: assert property (rxIndication |-> $past(rxFrameActive))
    else $error("rx indication outside a frame");
  AST_TX_ENABLE: assert property ($rose(txIndication) |-> $past(ctlReg[0]))
    else $error("tx indication while tx disabled");
  AST_RX_ENABLE: assert property ($rose(rxIndication) |-> $past(ctlReg[1]))
    else $error("rx indication while rx disabled");
  AST_HOLD_LIMIT: assert property (
    (ctlReg[3] && linkSpeed100 && holdReg == holdLimit) |-> !txIndication)
    else $error("tx indication held past its counted length");
  AST_DELIM_START: assert property (
    ($rose(txIndication) && ctlReg[2] && linkSpeed100 && txdReg[7:4] == 4'h0)
    |-> $past(txDelimDetect)) else $error("tx indication not started by delimiter");
  AST_NIBBLE_START: assert property (
    ($rose(txIndication) && !ctlReg[2] && linkSpeed100 && txdReg[7:4] == 4'h0)
    |-> $past(txFrameActive) && !$past(txFrameActive, 2))
    else $error("tx indication not started by first nibble");
  AST_WHOLE_FRAME: assert property (
    (txIndication && txFrameActive && ctlReg[0] && !ctlReg[3] && !regWrEn) |=> txIndication)
    else $error("tx indication dropped inside frame");
  AST_FIFO_SYNC: assert property (
    ($past(regWrEn) && $past(regAddr) == ADDR_TX_FIFO_SYNC_SELECT)
    |-> txFifoSyncMode == $past(regWrData[0])) else $error("sync mode not following write");
  AST_RD_UNMAPPED: assert property (($past(regRdEn) && $past(unmapped)) |-> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  cover property ($rose(txIndication));
  cover property ($rose(rxIndication));
  cover property (ctlReg[3] && $fell(txIndication) && txFrameActive);
endmodule : psm_packet_start_marker_checker
bind psm_packet_start_marker psm_packet_start_marker_checker psm_packet_start_marker_checker_i (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .linkSpeed100(linkSpeed100),
  .txFrameActive(txFrameActive), .txDelimDetect(txDelimDetect), .rxFrameActive(rxFrameActive),
  .rxDelimDetect(rxDelimDetect), .txIndication(txIndication), .rxIndication(rxIndication),
  .txFifoSyncMode(txFifoSyncMode));
`default_nettype wire

// >>> verif/psm_frame_source.sv
// frame source model: frame window with one delimiter pulse per frame
`timescale 1ns/10ps
`default_nettype none
module psm_frame_source (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] frameLen,
  input wire logic [7:0] delimAt,
  output logic frameActive,
  output logic delimDetect
);
  logic activeReg, activeNext, delimReg, delimNext;
  logic [7:0] cntReg, cntNext;
  // ==========================================================================
  // frame sequencer
  // ==========================================================================
  always_comb begin
    activeNext = activeReg;
    cntNext = cntReg;
    // pulse only inside the window, so delimAt must stay below frameLen
    delimNext = activeReg && cntReg == delimAt;
    if (go) begin
      activeNext = 1'b1;
      cntNext = 8'h01;
    end else if (activeReg) begin
      cntNext = cntReg + 8'h01;
      activeNext = cntReg != frameLen;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      activeReg <= 1'b0;
      delimReg <= 1'b0;
      cntReg <= 8'h00;
    end else begin
      activeReg <= activeNext;
      delimReg <= delimNext;
      cntReg <= cntNext;
    end
  end
  assign frameActive = activeReg;
  assign delimDetect = delimReg;
endmodule : psm_frame_source
`default_nettype wire

// >>> verif/psm_packet_start_marker_tb.sv
// self-checking bench of the packet start marker
`timescale 1ns/10ps
`default_nettype none
module psm_packet_start_marker_tb;
  import psm_pkg::*;
  logic ref_clk, rst, regWrEn, regRdEn, linkSpeed100, go;
  logic [15:0] regAddr, regWrData, regRdData, c, t, r;
  logic txIndication, rxIndication, txFifoSyncMode, frameActive, delimDetect;
  logic [7:0] frameLen, delimAt, rnd;
  int fail_count, checks_done, ctl, txd, rxd, cyc;
  logic [15:0] adr[4] = '{16'h9427, 16'h9428, 16'h9429, 16'h942A};
  logic [15:0] rstv[4] = '{16'h0000, 16'h0034, 16'h0000, 16'h0000};
  logic [15:0] msk[4] = '{16'h0001, 16'h007F, 16'hFFFF, 16'h1FFF};
  // ==========================================================================
  // frame table: control, tx delay, rx delay, speed, length, delimiter cycle
  // ==========================================================================
  logic [15:0] tC[8] = '{16'h0034, 16'h0037, 16'h003F, 16'h000B, 16'h0073, 16'h0037,
                         16'h0033, 16'h0037};
  logic [15:0] tT[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0060, 16'h1400,
                         16'h1400, 16'h1400};
  logic [15:0] tR[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0000,
                         16'h0000, 16'h0800};
  logic tS[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  int tL[8] = '{20, 20, 60, 5, 30, 30, 3, 20};
  int tD[8] = '{3, 3, 3, 2, 4, 6, 1, 5};

  psm_packet_start_marker psm_packet_start_marker_i (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .linkSpeed100(linkSpeed100), .txFrameActive(frameActive), .txDelimDetect(delimDetect),
    .rxFrameActive(frameActive), .rxDelimDetect(delimDetect), .txIndication(txIndication),
    .rxIndication(rxIndication), .txFifoSyncMode(txFifoSyncMode));
  psm_frame_source psm_frame_source_i (
    .ref_clk(ref_clk), .rst(rst), .go(go), .frameLen(frameLen), .delimAt(delimAt),
    .frameActive(frameActive), .delimDetect(delimDetect));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  // n of zero means the indication spans the frame
  function automatic logic expInd(input int e, input int len, input int s, input int d,
                                  input int en, input int n);
    return en != 0 && e >= s + d && e < len && (n == 0 || e < s + d + n);
  endfunction : expInd
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // an idle edge after each strobe keeps two strobes from meeting in one time step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge ref_clk) #1 regWrEn = 1'b0;
    @(posedge ref_clk) #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk) #1 regRdEn = 1'b0;
    check(regRdData, exp);
    @(posedge ref_clk) #1;
  endtask : rd
  task automatic cfg(input logic [15:0] cc, input logic [15:0] tt, input logic [15:0] rr,
                     input logic sp);
    wr(ADDR_PACKET_START_CONTROL, cc & 16'hFFFC);
    wr(ADDR_PACKET_START_TX_DELAY, tt);
    wr(ADDR_PACKET_START_RX_DELAY, rr);
    wr(ADDR_PACKET_START_CONTROL, cc);
    linkSpeed100 = sp;
    ctl = cc;
    txd = tt;
    rxd = rr;
  endtask : cfg
  task automatic frame(input int len, input int sfd);
    int s, dt, dr, n;
    s = ctl[2] ? sfd : 0;
    dt = ((linkSpeed100 ? (txd >> 4) & 15 : (txd >> 8) & 31) * 8 + 39) / 40;
    dr = linkSpeed100 ? (rxd >> 6) & 31 : (rxd >> 11) & 31;
    // 10M ticks fall every divide-th edge, the first one just after reset
    if (!linkSpeed100 && dr > 0) dr = dr * MII_10M_DIVIDE - (cyc + s - 19) % MII_10M_DIVIDE;
    n = ctl[3] ? ((ctl >> 4) & 7) * 8 + 8 : 0;
    frameLen = 8'(len);
    delimAt = 8'(sfd);
    go = 1'b1;
    @(posedge ref_clk) #1 go = 1'b0;
    for (int e = 0; e < len + 2; e++) begin
      @(posedge ref_clk) #1;
      check(16'(txIndication), 16'(expInd(e, len, s, dt, ctl[0], n)));
      check(16'(rxIndication), 16'(expInd(e, len, s, dr, ctl[1], n)));
    end
  endtask : frame

  initial begin
    ref_clk = 1'b0;
    forever #20 begin
      ref_clk = ~ref_clk;
      cyc += ref_clk;
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    linkSpeed100 = 1'b1;
    go = 1'b0;
    frameLen = 8'h00;
    delimAt = 8'h00;
    rnd = 8'h59;
    fail_count = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], rstv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 16'hFFFF);
      rd(adr[i], msk[i]);
    end
    check(16'(txFifoSyncMode), 16'h0001);
    wr(ADDR_TX_FIFO_SYNC_SELECT, 16'h0000);
    check(16'(txFifoSyncMode), 16'h0000);
    wr(16'h9426, 16'hFFFF);
    rd(16'h9426, 16'h0000);
    rd(16'h942B, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(ADDR_PACKET_START_RX_DELAY, {rnd, ~rnd});
      rd(ADDR_PACKET_START_RX_DELAY, {rnd, ~rnd});
    end
    for (int i = 0; i < 8; i++) begin
      cfg(tC[i], tT[i], tR[i], tS[i]);
      frame(tL[i], tD[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      c = {9'h000, rnd[6:2], 2'h3};
      rnd = lfsr(rnd);
      t = {8'h00, rnd[3:0], 4'h0};
      rnd = lfsr(rnd);
      r = {5'h00, rnd[4:0], 6'h00};
      rnd = lfsr(rnd);
      cfg(c, t, r, 1'b1);
      frame(10 + rnd % 40, 1 + rnd % 7);
    end
    end_sim();
  end
endmodule : psm_packet_start_marker_tb
`default_nettype wire
